//--- lcp_config_regs.v
/*
 * LED channel enable, boost configuration, phase delay and alternate
 * oscillator registers, reached by byte write and byte read cycles on a
 * two-wire serial link, plus the per-channel fault latch and the phase
 * delay generator.
 * Assumes SCL and SDA arrive asynchronously as pin levels with an
 * external pull-up; channel faults arrive asynchronously from the sinks.
 */
// Contract
// - Mask bit one enables channel, zero disables
// - Mask bit position equals channel number
// - Mask read zero for disabled or faulted
// - Clear then set mask bit retries channel
// - Mask resets to all six enabled
// - Two-bit field selects gate drive strength
// - Frequency bit: zero 1200 kHz, one 600
// - Bit zero enables string short detection
// - Top phase bit: even spacing period/N
// - Otherwise delay is step times period/255
// - Phase register resets to zero
// - Alternate oscillator select overrides frequency bit
// - Oscillator register resets to zero
// - Configuration resets to full drive, 600k, short
// - Byte write and byte read access
`timescale 1ns/100ps
`default_nettype none
`include "lcp_defs.vh"

module lcp_config_regs (
   input  wire                     clk,
   input  wire                     reset_n,
   input  wire                     sclIn,
   input  wire                     sdaIn,
   output reg                      sdaOut_q,
   output reg                      sdaOe_q,
   input  wire [`LCP_NUM_CH-1:0]   channelFault,
   input  wire                     pwmCycleStart,
   input  wire [15:0]              pwmPeriodCycles,
   output reg  [`LCP_NUM_CH-1:0]   channelEnable_q,
   output reg  [1:0]               boostDriveStrength_q,
   output reg  [1:0]               switchFreqCode_q,
   output reg                      stringShortEnable_q,
   output wire [`LCP_NUM_CH-1:0]   channelPwmStart
);

   localparam [3:0] ST_IDLE     = 4'h0;
   localparam [3:0] ST_ADDR     = 4'h1;
   localparam [3:0] ST_ADDR_ACK = 4'h2;
   localparam [3:0] ST_REG      = 4'h3;
   localparam [3:0] ST_REG_ACK  = 4'h4;
   localparam [3:0] ST_WDAT     = 4'h5;
   localparam [3:0] ST_WDAT_ACK = 4'h6;
   localparam [3:0] ST_RDAT     = 4'h7;
   localparam [3:0] ST_RDAT_ACK = 4'h8;
   localparam [3:0] ST_RDAT_LD  = 4'h9;

   localparam [2:0] SEL_CONFIG = 3'h0;
   localparam [2:0] SEL_MASK   = 3'h1;
   localparam [2:0] SEL_PHASE  = 3'h2;
   localparam [2:0] SEL_OSC    = 3'h3;
   localparam [2:0] SEL_NONE   = 3'h4;

   // Pin synchronisers, three stages each
   reg  [2:0]              sclSync_q;
   reg  [2:0]              sdaSync_q;
   reg                     sclF_q;
   reg                     sdaF_q;
   wire                    sclStable;
   wire                    sdaStable;
   wire                    sclRise;
   wire                    sclFall;
   wire                    startSeen;
   wire                    stopSeen;

   reg  [3:0]              state_q;
   reg  [2:0]              bitCnt_q;
   reg  [7:0]              shift_q;
   reg  [7:0]              ptr_q;
   reg                     readDir_q;
   reg                     ackOn_q;

   reg  [7:0]              config_q;
   reg  [`LCP_NUM_CH-1:0]  mask_q;
   reg  [7:0]              phase_q;
   reg  [7:0]              osc_q;
   reg  [`LCP_NUM_CH-1:0]  faultLatch_q;
   reg  [`LCP_NUM_CH-1:0]  faultLatch_d;
   wire [`LCP_NUM_CH-1:0]  faultSync;
   wire [`LCP_NUM_CH-1:0]  healthy;
   wire [7:0]              byteIn;
   reg  [7:0]              readData;
   reg                     wrStrobe_q;

   // Register number to register selector
   function [2:0] regSel;
      input [7:0] num;
      begin
         case (num)
            `LCP_REG_BOOST_CONFIG: regSel = SEL_CONFIG;
            `LCP_REG_CHANNEL_MASK: regSel = SEL_MASK;
            `LCP_REG_PHASE_DELAY:  regSel = SEL_PHASE;
            `LCP_REG_ALT_OSC:      regSel = SEL_OSC;
            default:               regSel = SEL_NONE;
         endcase
      end
   endfunction

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclSync_q <= 3'h7;
         sdaSync_q <= 3'h7;
         sclF_q    <= 1'b1;
         sdaF_q    <= 1'b1;
      end else begin
         sclSync_q <= {sclSync_q[1:0], sclIn};
         sdaSync_q <= {sdaSync_q[1:0], sdaIn};
         if (sclStable)
            sclF_q <= sclSync_q[2];
         if (sdaStable)
            sdaF_q <= sdaSync_q[2];
      end
   end

   assign sclStable = (sclSync_q[1] == sclSync_q[2]);
   assign sdaStable = (sdaSync_q[1] == sdaSync_q[2]);
   assign sclRise   = sclStable && sclSync_q[2] && !sclF_q;
   assign sclFall   = sclStable && !sclSync_q[2] && sclF_q;
   assign startSeen = sdaStable && !sdaSync_q[2] && sdaF_q && sclF_q && !sclFall;
   assign stopSeen  = sdaStable && sdaSync_q[2] && !sdaF_q && sclF_q && !sclFall;
   assign byteIn    = {shift_q[6:0], sdaF_q};

   // Channel fault inputs
   genvar g;
   generate
      for (g = 0; g < `LCP_NUM_CH; g = g + 1) begin : gFaultSync
         reg [2:0] s_q;
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n)
               s_q <= 3'h0;
            else
               s_q <= {s_q[1:0], channelFault[g]};
         end
         assign faultSync[g] = s_q[2] & s_q[1];
      end
   endgenerate

   always @* begin
      faultLatch_d = (faultLatch_q | faultSync) & mask_q;
   end

   assign healthy = mask_q & ~faultLatch_q;

   always @* begin
      case (regSel(ptr_q))
         SEL_CONFIG: readData = config_q;
         SEL_MASK:   readData = {`LCP_MASK_PAD, healthy};
         SEL_PHASE:  readData = phase_q;
         SEL_OSC:    readData = osc_q;
         default:    readData = `LCP_READ_UNMAPPED;
      endcase
   end

   // byte write and byte read cycles
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q   <= ST_IDLE;
         bitCnt_q  <= `LCP_BIT_FIRST;
         shift_q   <= 8'h0;
         ptr_q     <= 8'h0;
         readDir_q <= 1'b0;
         ackOn_q   <= 1'b0;
         sdaOe_q   <= 1'b0;
         sdaOut_q  <= 1'b0;
         wrStrobe_q <= 1'b0;
      end else begin
         wrStrobe_q <= 1'b0;
         sdaOut_q <= 1'b0;
         if (startSeen) begin
            state_q  <= ST_ADDR;
            bitCnt_q <= `LCP_BIT_FIRST;
            ackOn_q  <= 1'b0;
            sdaOe_q  <= 1'b0;
         end else if (stopSeen) begin
            state_q <= ST_IDLE;
            ackOn_q <= 1'b0;
            sdaOe_q <= 1'b0;
         end else if (sclRise) begin
            case (state_q)
               ST_ADDR, ST_REG, ST_WDAT: begin
                  shift_q  <= byteIn;
                  bitCnt_q <= bitCnt_q + 3'h1;
                  if (bitCnt_q == `LCP_BIT_LAST) begin
                     if (state_q == ST_ADDR) begin
                        readDir_q <= sdaF_q;
                        state_q   <= (shift_q[6:0] == `LCP_DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                     end else if (state_q == ST_REG) begin
                        ptr_q   <= byteIn;
                        state_q <= ST_REG_ACK;
                     end else begin
                        wrStrobe_q <= 1'b1;
                        state_q    <= ST_WDAT_ACK;
                     end
                  end
               end
               ST_RDAT: begin
                  bitCnt_q <= bitCnt_q + 3'h1;
                  if (bitCnt_q == `LCP_BIT_LAST)
                     state_q <= ST_RDAT_ACK;
               end
               ST_RDAT_ACK: begin
                  state_q <= sdaF_q ? ST_IDLE : ST_RDAT_LD;
               end
               default: begin
                  state_q <= state_q;
               end
            endcase
         end else if (sclFall) begin
            case (state_q)
               ST_ADDR_ACK, ST_REG_ACK, ST_WDAT_ACK: begin
                  if (!ackOn_q) begin
                     ackOn_q <= 1'b1;
                     sdaOe_q <= 1'b1;
                  end else begin
                     ackOn_q  <= 1'b0;
                     bitCnt_q <= `LCP_BIT_FIRST;
                     if (state_q == ST_ADDR_ACK && readDir_q) begin
                        state_q <= ST_RDAT;
                        sdaOe_q <= ~readData[7];
                        shift_q <= {readData[6:0], 1'b0};
                     end else begin
                        sdaOe_q <= 1'b0;
                        state_q <= (state_q == ST_ADDR_ACK) ? ST_REG : ST_WDAT;
                     end
                  end
               end
               ST_RDAT: begin
                  sdaOe_q <= ~shift_q[7];
                  shift_q <= {shift_q[6:0], 1'b0};
               end
               ST_RDAT_ACK: begin
                  sdaOe_q <= 1'b0;
               end
               ST_RDAT_LD: begin
                  bitCnt_q <= `LCP_BIT_FIRST;
                  state_q  <= ST_RDAT;
                  sdaOe_q  <= ~readData[7];
                  shift_q  <= {readData[6:0], 1'b0};
               end
               default: begin
                  sdaOe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Register file and derived controls
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         config_q             <= `LCP_RST_BOOST_CONFIG;
         mask_q               <= `LCP_RST_CHANNEL_MASK;
         phase_q              <= `LCP_RST_PHASE_DELAY;
         osc_q                <= `LCP_RST_ALT_OSC;
         faultLatch_q         <= {`LCP_NUM_CH{1'b0}};
         channelEnable_q      <= {`LCP_NUM_CH{1'b0}};
         boostDriveStrength_q <= 2'h0;
         switchFreqCode_q     <= `LCP_FREQ_1200K;
         stringShortEnable_q  <= 1'b0;
      end else begin
         if (wrStrobe_q) begin
            case (regSel(ptr_q))
               SEL_CONFIG: config_q <= shift_q;
               SEL_MASK:   mask_q   <= shift_q[`LCP_NUM_CH-1:0];
               SEL_PHASE:  phase_q  <= shift_q;
               SEL_OSC:    osc_q    <= shift_q;
               default:    osc_q    <= osc_q;
            endcase
         end
         faultLatch_q    <= faultLatch_d;
         channelEnable_q <= healthy;
         boostDriveStrength_q <= config_q[`LCP_CFG_DRIVE_HI:`LCP_CFG_DRIVE_LO];
         stringShortEnable_q  <= config_q[`LCP_CFG_SHORT_BIT];
         if (osc_q[`LCP_OSC_SEL_BIT])
            switchFreqCode_q <= `LCP_FREQ_800K;
         else if (config_q[`LCP_CFG_FREQ_BIT])
            switchFreqCode_q <= `LCP_FREQ_600K;
         else
            switchFreqCode_q <= `LCP_FREQ_1200K;
      end
   end

   lcp_phase_gen uPhase (
      .clk             (clk),
      .reset_n         (reset_n),
      .pwmCycleStart   (pwmCycleStart),
      .pwmPeriodCycles (pwmPeriodCycles),
      .healthyMask     (healthy),
      .evenSpacing     (phase_q[`LCP_PH_EVEN_BIT]),
      .stepValue       (phase_q[`LCP_PH_STEP_HI:0]),
      .channelStart_q  (channelPwmStart)
   );

endmodule
`default_nettype wire

//--- lcp_defs.vh
/*
 * Constants for the LED channel phase and configuration register block:
 * register numbers, reset values, field positions, frequency codes and
 * two-wire link settings.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef LCP_DEFS_VH
`define LCP_DEFS_VH

// Register numbers on the two-wire link
`define LCP_REG_BOOST_CONFIG   8'h08
`define LCP_REG_CHANNEL_MASK   8'h09
`define LCP_REG_PHASE_DELAY    8'h0a
`define LCP_REG_ALT_OSC        8'h7f

// Reset values and unmapped read value
`define LCP_RST_BOOST_CONFIG   8'h1f
`define LCP_RST_CHANNEL_MASK   6'h3f
`define LCP_RST_PHASE_DELAY    8'h00
`define LCP_RST_ALT_OSC        8'h00
`define LCP_READ_UNMAPPED      8'h00

// Field positions
`define LCP_CFG_DRIVE_HI       4
`define LCP_CFG_DRIVE_LO       3
`define LCP_CFG_FREQ_BIT       2
`define LCP_CFG_SHORT_BIT      0
`define LCP_PH_EVEN_BIT        7
`define LCP_PH_STEP_HI         6
`define LCP_OSC_SEL_BIT        7

// Channel count and mask read padding
`define LCP_NUM_CH             6
`define LCP_MASK_PAD           2'h0

// Switching frequency codes driven to the boost oscillator
`define LCP_FREQ_1200K         2'h0
`define LCP_FREQ_600K          2'h1
`define LCP_FREQ_800K          2'h2

// Programmed-delay divisor (period / 255 per step)
`define LCP_STEP_DEN           9'h0ff

// Two-wire link: 7-bit device address, value arbitrary
`define LCP_DEV_ADDR           7'h2c
`define LCP_BIT_LAST           3'h7
`define LCP_BIT_FIRST          3'h0

`endif

//--- lcp_phase_gen.v
/*
 * Phase delay generator: on each PWM cycle start, fires a one-cycle start
 * pulse for each enabled channel in channel order, each one computed
 * delay after the previous enabled channel.
 * Assumes pwmCycleStart is a one-cycle pulse on clk and that the period
 * in cycles is steady while a cycle is being sequenced.
 */
`timescale 1ns/100ps
`default_nettype none
`include "lcp_defs.vh"

module lcp_phase_gen (
   input  wire                     clk,
   input  wire                     reset_n,
   input  wire                     pwmCycleStart,
   input  wire [15:0]              pwmPeriodCycles,
   input  wire [`LCP_NUM_CH-1:0]   healthyMask,
   input  wire                     evenSpacing,
   input  wire [6:0]               stepValue,
   output reg  [`LCP_NUM_CH-1:0]   channelStart_q
);

   reg  [27:0]             acc_q;
   reg  [27:0]             target_q;
   reg  [27:0]             delta_q;
   reg  [8:0]              den_q;
   reg  [2:0]              cur_q;
   reg                     running_q;
   reg  [`LCP_NUM_CH-1:0]  order_q;
   wire [2:0]              firstCh;
   wire [2:0]              nextCh;
   wire                    nextValid;

   function [2:0] countOnes;
      input [`LCP_NUM_CH-1:0] m;
      integer i;
      begin
         countOnes = 3'h0;
         for (i = 0; i < `LCP_NUM_CH; i = i + 1)
            countOnes = countOnes + {2'h0, m[i]};
      end
   endfunction

   // Lowest enabled channel at or above a given index; 7 means none
   function [2:0] firstFrom;
      input [`LCP_NUM_CH-1:0] m;
      input [2:0]             from;
      integer i;
      begin
         firstFrom = 3'h7;
         for (i = `LCP_NUM_CH - 1; i >= 0; i = i - 1)
            if (m[i] && (i >= from))
               firstFrom = i[2:0];
      end
   endfunction

   assign firstCh   = firstFrom(healthyMask, 3'h0);
   assign nextCh    = firstFrom(order_q, cur_q + 3'h1);
   assign nextValid = (nextCh != 3'h7);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_q          <= 28'h0;
         target_q       <= 28'h0;
         delta_q        <= 28'h0;
         den_q          <= 9'h0;
         cur_q          <= 3'h0;
         running_q      <= 1'b0;
         order_q        <= {`LCP_NUM_CH{1'b0}};
         channelStart_q <= {`LCP_NUM_CH{1'b0}};
      end else begin
         channelStart_q <= {`LCP_NUM_CH{1'b0}};
         if (pwmCycleStart) begin
            acc_q     <= 28'h0;
            target_q  <= 28'h0;
            cur_q     <= firstCh;
            order_q   <= healthyMask;
            running_q <= (firstCh != 3'h7);
            if (evenSpacing) begin
               den_q   <= {6'h0, countOnes(healthyMask)};
               delta_q <= {12'h0, pwmPeriodCycles};
            end else begin
               den_q   <= `LCP_STEP_DEN;
               delta_q <= {5'h0, {7'h0, pwmPeriodCycles} * {16'h0, stepValue}};
            end
         end else if (running_q) begin
            acc_q <= acc_q + {19'h0, den_q};
            if (acc_q >= target_q) begin
               channelStart_q[cur_q] <= 1'b1;
               target_q              <= target_q + delta_q;
               cur_q                 <= nextCh;
               running_q             <= nextValid;
            end
         end
      end
   end

endmodule
`default_nettype wire

//--- lcp_host_model.sv
/* Two-wire host model issuing byte write and byte read cycles.
   Assumes the bench resolves SDA as a pulled-up wire from all pull-low enables. */
`timescale 1ns/100ps
`default_nettype none
module lcp_host_model (
   input  wire logic clk,
   input  wire logic sdaWire,
   output var  logic sclPin,
   output var  logic sdaPullLow
);
   initial begin
      sclPin = 1'b1;
      sdaPullLow = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic start();
      if (!sclPin) begin
         tick(7);
         sdaPullLow = 1'b0;
         tick(5);
         sclPin = 1'b1;
      end
      tick(6);
      sdaPullLow = 1'b1;
      tick(12);
      sclPin = 1'b0;
   endtask
   task automatic stop();
      tick(7);
      sdaPullLow = 1'b1;
      tick(5);
      sclPin = 1'b1;
      tick(6);
      sdaPullLow = 1'b0;
      tick(12);
   endtask
   // Data held over the whole high phase
   task automatic bitx(input logic b, output logic r);
      tick(7);
      sdaPullLow = ~b;
      tick(5);
      sclPin = 1'b1;
      tick(11);
      r = sdaWire;
      tick(1);
      sclPin = 1'b0;
   endtask
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic getByte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(~more, r);
   endtask
   task automatic writeReg(input logic [6:0] a, input logic [7:0] rg, input logic [7:0] d,
                           output logic ok);
      logic k0, k1, k2;
      start();
      sendByte({a, 1'b0}, k0);
      sendByte(rg, k1);
      sendByte(d, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   // byte read cycle, host ends with no acknowledge
   task automatic readReg(input logic [6:0] a, input logic [7:0] rg, output logic [7:0] d,
                          output logic ok);
      logic k0, k1, k2;
      start();
      sendByte({a, 1'b0}, k0);
      sendByte(rg, k1);
      start();
      sendByte({a, 1'b1}, k2);
      getByte(1'b0, d);
      stop();
      ok = k0 & k1 & k2;
   endtask
   // read twice, host acknowledges the first byte
   task automatic readTwice(input logic [6:0] a, input logic [7:0] rg, output logic [7:0] d0,
                            output logic [7:0] d1);
      logic k;
      start();
      sendByte({a, 1'b0}, k);
      sendByte(rg, k);
      start();
      sendByte({a, 1'b1}, k);
      getByte(1'b1, d0);
      getByte(1'b0, d1);
      stop();
   endtask
endmodule
`default_nettype wire

//--- lcp_config_regs_props.sv
/* Checker for the LED channel register block, watching its ports only.
   Assumes one clock and an active-low reset; bound at the foot of this file. */
`timescale 1ns/100ps
`default_nettype none
module lcp_config_regs_props (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   input  wire logic        sdaOut_q,
   input  wire logic        sdaOe_q,
   input  wire logic [5:0]  channelFault,
   input  wire logic        pwmCycleStart,
   input  wire logic [15:0] pwmPeriodCycles,
   input  wire logic [5:0]  channelEnable_q,
   input  wire logic [1:0]  boostDriveStrength_q,
   input  wire logic [1:0]  switchFreqCode_q,
   input  wire logic        stringShortEnable_q,
   input  wire logic [5:0]  channelPwmStart
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_sda_open_drain: assert property (sdaOe_q |-> !sdaOut_q)
      else $error("data line driven high");
   chk_sda_scl_low: assert property (!$stable(sdaOe_q) |-> !sclIn)
      else $error("data drive moved with clock high");
   chk_cfg_scl_high: assert property (
      !$stable({boostDriveStrength_q, switchFreqCode_q, stringShortEnable_q}) |-> sclIn)
      else $error("config output moved outside a write");
   chk_fault_disables: assert property (
      (channelEnable_q & channelFault & $past(channelFault, 3) & $past(channelFault, 6))
      == 6'h00) else $error("faulted channel still enabled");
   chk_freq_code_legal: assert property (switchFreqCode_q != 2'h3)
      else $error("unknown frequency code");
   chk_one_start: assert property ($onehot0(channelPwmStart))
      else $error("two channel starts in one cycle");
   chk_start_enabled: assert property ((channelPwmStart & ~channelEnable_q) == 6'h00)
      else $error("start on disabled channel");
   chk_first_start: assert property (
      pwmCycleStart && channelEnable_q != 6'h00 |-> ##2
      channelPwmStart == ($past(channelEnable_q, 2) & (~$past(channelEnable_q, 2) + 6'h01)))
      else $error("first channel start wrong");
   chk_reset_defaults: assert property ($rose(reset_n) |-> ##1
      (boostDriveStrength_q == 2'h3 && switchFreqCode_q == 2'h1 &&
       stringShortEnable_q == 1'h1 && channelEnable_q == 6'h3f))
      else $error("outputs not at reset defaults");
endmodule
bind lcp_config_regs lcp_config_regs_props chk (.clk(clk), .reset_n(reset_n), .sclIn(sclIn),
   .sdaIn(sdaIn), .sdaOut_q(sdaOut_q), .sdaOe_q(sdaOe_q), .channelFault(channelFault),
   .pwmCycleStart(pwmCycleStart), .pwmPeriodCycles(pwmPeriodCycles),
   .channelEnable_q(channelEnable_q), .boostDriveStrength_q(boostDriveStrength_q),
   .switchFreqCode_q(switchFreqCode_q), .stringShortEnable_q(stringShortEnable_q),
   .channelPwmStart(channelPwmStart));
`default_nettype wire

//--- testbench.sv
/* Bench for the LED channel register block: host model on the link,
   fault and PWM stimulus. Assumes the checker binds itself. */
`timescale 1ns/100ps
`default_nettype none
`include "lcp_defs.vh"
module testbench;
   logic        clk, reset_n, sclPin, hostLow, pwmCycleStart, sdaOut, sdaOe, shortEn;
   logic [5:0]  channelFault, channelEnable, pwmStart;
   logic [15:0] pwmPeriodCycles;
   logic [1:0]  drive, freq;
   wire logic   sdaWire;
   int          failures, n_compared, cyc, startCyc;
   int          seen [6];
   assign sdaWire = ~(hostLow | sdaOe);
   lcp_host_model host (.clk(clk), .sdaWire(sdaWire), .sclPin(sclPin), .sdaPullLow(hostLow));
   lcp_config_regs dut (.clk(clk), .reset_n(reset_n), .sclIn(sclPin), .sdaIn(sdaWire),
      .sdaOut_q(sdaOut), .sdaOe_q(sdaOe), .channelFault(channelFault),
      .pwmCycleStart(pwmCycleStart), .pwmPeriodCycles(pwmPeriodCycles),
      .channelEnable_q(channelEnable), .boostDriveStrength_q(drive),
      .switchFreqCode_q(freq), .stringShortEnable_q(shortEn), .channelPwmStart(pwmStart));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] rg, input logic [7:0] d);
      logic ok;
      host.writeReg(`LCP_DEV_ADDR, rg, d, ok);
      check("write ack", ok, 1'h1);
   endtask
   task automatic rd(input logic [7:0] rg, input logic [7:0] exp, input string what);
      logic       ok;
      logic [7:0] d;
      host.readReg(`LCP_DEV_ADDR, rg, d, ok);
      check("read ack", ok, 1'h1);
      check(what, d, exp);
   endtask
   // Start offsets per enabled channel in order
   task automatic runPhase(input logic [5:0] mask, input logic [7:0] ph, input int period,
                           input int delay);
      int idx;
      wr(8'h09, {2'h0, mask});
      wr(8'h0a, ph);
      pwmPeriodCycles = period[15:0];
      foreach (seen[i])
         seen[i] = -1;
      @(negedge clk) pwmCycleStart = 1'b1;
      @(negedge clk) pwmCycleStart = 1'b0;
      repeat (period + 8) @(negedge clk);
      idx = 0;
      for (int i = 0; i < 6; i++) begin
         if (mask[i]) begin
            check("start lag", seen[i] - startCyc, 2 + idx * delay);
            idx++;
         end else
            check("no start", seen[i], 16'hffff);
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pwmCycleStart)
         startCyc <= cyc;
      for (int i = 0; i < 6; i++)
         if (pwmStart[i])
            seen[i] <= cyc;
      if (cyc == 60000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      logic       ok;
      logic [7:0] d;
      logic [7:0] v;
      reset_n = 1'b0;
      channelFault = 6'h00;
      pwmCycleStart = 1'b0;
      pwmPeriodCycles = 16'h0190;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (6) @(negedge clk);
      check("drive", drive, 2'h3);
      check("freq", freq, `LCP_FREQ_600K);
      check("short", shortEn, 1'h1);
      check("enable", channelEnable, 6'h3f);
      rd(8'h08, 8'h1f, "config reset");
      rd(8'h09, 8'h3f, "mask reset");
      rd(8'h0a, 8'h00, "phase reset");
      rd(8'h7f, 8'h00, "osc reset");
      rd(8'h20, 8'h00, "unmapped");
      host.readReg(`LCP_DEV_ADDR ^ 7'h01, 8'h08, d, ok);
      check("foreign ack", ok, 1'h0);
      $display("reset test done");
      for (int k = 0; k < 4; k++) begin
         v = {3'h0, k[1:0], k[0], 1'b0, k[1]};
         wr(8'h08, v);
         check("drive", drive, k[1:0]);
         check("freq", freq, k[0] ? `LCP_FREQ_600K : `LCP_FREQ_1200K);
         check("short", shortEn, k[1]);
         rd(8'h08, v, "config");
      end
      host.readTwice(`LCP_DEV_ADDR, 8'h08, d, v);
      check("repeat first", d, 8'h1d);
      check("repeat second", v, 8'h1d);
      wr(8'h7f, 8'h80);
      check("freq", freq, `LCP_FREQ_800K);
      rd(8'h7f, 8'h80, "osc");
      wr(8'h7f, 8'h00);
      check("freq", freq, `LCP_FREQ_600K);
      $display("config test done");
      for (int k = 0; k < 6; k++) begin
         wr(8'h09, 8'hc0 | (8'h01 << k));
         check("enable", channelEnable, 6'h01 << k);
         rd(8'h09, 8'h01 << k, "mask");
      end
      wr(8'h09, 8'h3f);
      channelFault = 6'h04;
      repeat (8) @(negedge clk);
      check("faulted", channelEnable, 6'h3b);
      channelFault = 6'h00;
      rd(8'h09, 8'h3b, "mask fault");
      wr(8'h09, 8'h3b);
      check("retry off", channelEnable, 6'h3b);
      wr(8'h09, 8'h3f);
      check("retry on", channelEnable, 6'h3f);
      $display("mask test done");
      // every total delay kept within one period
      runPhase(6'h2d, 8'h80, 400, 100);
      runPhase(6'h3f, 8'h80, 600, 100);
      runPhase(6'h2d, 8'h03, 510, 6);
      $display("phase test done");
      finish_test();
   end
endmodule
`default_nettype wire
